// ---- design/sup_pkg.sv ----
// constants, types and frame layouts for the node supervision block
// assumes one 100 MHz system clock shared by every user of this package
package sup_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    localparam logic [10:0] NMT_ID = 11'h000;
    localparam logic [10:0] EMCY_BASE = 11'h080;
    localparam logic [10:0] GUARD_BASE = 11'h700;
    localparam logic [3:0] NMT_DLC = 4'h2;
    localparam logic [3:0] EMCY_DLC = 4'h8;
    localparam logic [3:0] STATE_DLC = 4'h1;
    localparam logic [3:0] BOOT_DLC = 4'h0;

    localparam logic [7:0] CMD_START = 8'h01;
    localparam logic [7:0] CMD_STOP = 8'h02;
    localparam logic [7:0] CMD_PREOP = 8'h80;
    localparam logic [7:0] CMD_RST_NODE = 8'h81;
    localparam logic [7:0] CMD_RST_COMM = 8'h82;
    localparam logic [7:0] NODE_ALL = 8'h00;

    localparam logic [15:0] EMCY_CODE = 16'h1000;
    localparam logic [7:0] EMCY_ERR_REG = 8'h81;
    localparam logic [7:0] APP_INIT = 8'h01;
    localparam logic [7:0] APP_CFG = 8'h02;
    localparam logic [7:0] APP_INDEX = 8'h03;
    localparam logic [7:0] APP_DI_RD = 8'h10;
    localparam logic [7:0] APP_DO_WR = 8'h11;
    localparam logic [7:0] APP_RW_BASE = 8'h20;
    localparam logic [7:0] APP_PAR_BASE = 8'h30;
    localparam logic [7:0] APP_DIAG_BASE = 8'h40;
    localparam logic [7:0] APP_PROC_BASE = 8'h80;
    localparam logic [7:0] APP_COUPLER = 8'hAA;

    typedef enum logic [6:0] {
        ST_INIT = 7'b0000000,
        ST_STOPPED = 7'b0000100,
        ST_OPER = 7'b0000101,
        ST_PREOP = 7'b1111111
    } nmt_state_t;

    typedef enum logic [3:0] {
        FK_INIT = 4'b0000,
        FK_CFG = 4'b0001,
        FK_INDEX = 4'b0010,
        FK_DI_RD = 4'b0011,
        FK_DO_WR = 4'b0100,
        FK_RW = 4'b0101,
        FK_PAR = 4'b0110,
        FK_DIAG = 4'b0111,
        FK_PROC = 4'b1000,
        FK_COUPLER = 4'b1001
    } fault_kind_t;

    // info[0] is the first additional byte of the fault
    typedef struct packed {
        fault_kind_t kind;
        logic [2:0] sub;
        logic [7:0] slot;
        logic [3:0][7:0] info;
    } fault_t;

    // data[0] is byte 0 on the wire
    typedef struct packed {
        logic [10:0] id;
        logic rtr;
        logic [3:0] dlc;
        logic [7:0][7:0] data;
    } can_frame_t;
endpackage

// ---- design/emcy_encoder.sv ----
// maps a back-panel fault report to emergency bytes 3 to 7
// assumes the caller registers the result before it reaches a pin
`timescale 1ns/100ps
module emcy_encoder (
    // fault in
    input wire sup_pkg::fault_t fault_i,
    // bytes 3..7, index 0 is byte 3
    output logic [4:0][7:0] app_o
);
    wire [7:0] sub8 = {5'h00, fault_i.sub};
    wire [7:0] par8 = {6'h00, fault_i.sub[1:0]};

    always_comb begin
        app_o = '0;
        unique case (fault_i.kind)
            sup_pkg::FK_INIT: app_o[0] = sup_pkg::APP_INIT;
            sup_pkg::FK_CFG: begin
                app_o[0] = sup_pkg::APP_CFG;
                app_o[1] = fault_i.slot;
                app_o[2] = fault_i.info[0];
                app_o[3] = fault_i.info[1];
            end
            sup_pkg::FK_INDEX: app_o[0] = sup_pkg::APP_INDEX;
            sup_pkg::FK_DI_RD: app_o[0] = sup_pkg::APP_DI_RD;
            sup_pkg::FK_DO_WR: app_o[0] = sup_pkg::APP_DO_WR;
            sup_pkg::FK_RW: begin
                app_o[0] = sup_pkg::APP_RW_BASE | sub8;
                app_o[1] = fault_i.slot;
                app_o[2] = fault_i.info[0];
                app_o[3] = fault_i.info[1];
            end
            sup_pkg::FK_PAR: begin
                app_o[0] = sup_pkg::APP_PAR_BASE | par8;
                app_o[1] = fault_i.slot;
                app_o[2] = fault_i.info[0];
                app_o[3] = fault_i.info[1];
            end
            sup_pkg::FK_DIAG: begin
                app_o[0] = 8'(sup_pkg::APP_DIAG_BASE + fault_i.slot);
                app_o[4:1] = fault_i.info;
            end
            sup_pkg::FK_PROC: begin
                app_o[0] = 8'(sup_pkg::APP_PROC_BASE + fault_i.slot);
                app_o[4:1] = fault_i.info;
            end
            sup_pkg::FK_COUPLER: begin
                app_o[0] = sup_pkg::APP_COUPLER;
                app_o[1] = fault_i.info[0];
                app_o[2] = fault_i.info[1];
                app_o[3] = fault_i.info[2];
            end
            default: app_o = '0;
        endcase
    end
endmodule

// ---- design/period_timer.sv ----
// periodic millisecond timer: pulses when limit ticks have elapsed
// assumes tick_i is a one-cycle pulse on the same clock
`timescale 1ns/100ps
module period_timer (
    // clock and control
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [23:0] limit_i,
    // event
    output logic expire_o
);
    logic [23:0] count_r;
    wire at_end = (count_r + 24'h000001) >= limit_i;
    // restart beats a coincident expiry so a fresh request always gets a full period
    assign expire_o = ce_i && run_i && !restart_i && tick_i && at_end;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count_r <= 24'h000000;
        end else if (ce_i) begin
            // run and restart may move while frozen, so they only act when enabled
            if (!run_i || restart_i) begin
                count_r <= 24'h000000;
            end else if (tick_i) begin
                count_r <= at_end ? 24'h000000 : count_r + 24'h000001;
            end
        end
    end
endmodule

// ---- design/canopen_node_supervision.sv ----
// network management, guarding, heartbeat and emergency framing of a bus node
// assumes a frame controller with valid/ready on transmit and a one-cycle
// receive strobe on this clock; node number and timing come in as plain ports
`timescale 1ns/100ps
module canopen_node_supervision #(
    parameter int TICK_CYCLES_P = sup_pkg::TICK_CYCLES
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // node strap and timing configuration
    input wire logic [6:0] node_id_i,
    input wire logic [15:0] guard_time_i,
    input wire logic [7:0] life_factor_i,
    input wire logic [15:0] hb_period_i,
    // received frames
    input wire logic rx_valid_i,
    input wire sup_pkg::can_frame_t rx_frame_i,
    // transmitted frames
    output logic tx_valid_o,
    output sup_pkg::can_frame_t tx_frame_o,
    input wire logic tx_ready_i,
    // back-panel fault reports
    input wire logic fault_valid_i,
    input wire sup_pkg::fault_t fault_i,
    output logic fault_ready_o,
    // status
    output sup_pkg::nmt_state_t nmt_state_o,
    output logic master_fault_o,
    output logic guard_active_o,
    output logic node_reset_o,
    output logic comm_reset_o
);
    sup_pkg::nmt_state_t state_r, state_nxt;
    sup_pkg::can_frame_t tx_frame_r, tx_nxt;
    logic [6:0] node_s1_r, node_r;
    logic [23:0] tick_cnt_r;
    logic tx_valid_r, tx_boot_r;
    logic boot_pend_r, emcy_pend_r, guard_pend_r, hb_pend_r;
    logic [4:0][7:0] emcy_app_r;
    logic [4:0][7:0] enc_app;
    logic guard_on_r, master_fault_r, life_done_r, toggle_r;
    logic node_reset_r, comm_reset_r;
    logic guard_exp, life_exp, hb_exp;

    // node number is a strap from outside the clock domain; no reset, so it
    // settles while reset is held and the boot frame already carries it
    always_ff @(posedge clock_i) begin
        if (ce_i) begin
            node_s1_r <= node_id_i;
            node_r <= node_s1_r;
        end
    end

    wire [10:0] node11 = {4'h0, node_r};
    wire [10:0] emcy_id = sup_pkg::EMCY_BASE + node11;
    wire [10:0] guard_id = sup_pkg::GUARD_BASE + node11;

    // millisecond tick
    wire tick = tick_cnt_r == 24'(TICK_CYCLES_P - 1);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tick_cnt_r <= 24'h000000;
        end else if (ce_i) begin
            tick_cnt_r <= tick ? 24'h000000 : tick_cnt_r + 24'h000001;
        end
    end

    // receive decode
    wire nmt_frame = rx_valid_i && !rx_frame_i.rtr && rx_frame_i.id == sup_pkg::NMT_ID
                     && rx_frame_i.dlc == sup_pkg::NMT_DLC;
    wire nmt_mine = rx_frame_i.data[1] == {1'b0, node_r}
                    || rx_frame_i.data[1] == sup_pkg::NODE_ALL;
    wire nmt_hit = ce_i && nmt_frame && nmt_mine;
    wire [7:0] cmd = rx_frame_i.data[0];
    wire cmd_start = nmt_hit && cmd == sup_pkg::CMD_START;
    wire cmd_stop = nmt_hit && cmd == sup_pkg::CMD_STOP;
    wire cmd_preop = nmt_hit && cmd == sup_pkg::CMD_PREOP;
    wire cmd_rst_node = nmt_hit && cmd == sup_pkg::CMD_RST_NODE;
    wire cmd_rst_comm = nmt_hit && cmd == sup_pkg::CMD_RST_COMM;
    wire cmd_reset = cmd_rst_node || cmd_rst_comm;
    wire guard_req = ce_i && rx_valid_i && rx_frame_i.rtr && rx_frame_i.id == guard_id;

    // supervision timers
    wire guard_en = guard_time_i != 16'h0000 && life_factor_i != 8'h00;
    wire [23:0] life_limit = guard_time_i * life_factor_i;
    wire guard_run = guard_on_r && guard_en && !cmd_reset;
    wire hb_run = hb_period_i != 16'h0000 && state_r != sup_pkg::ST_INIT && !cmd_reset;

    period_timer guard_tmr (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .run_i(guard_run),
        .restart_i(guard_req),
        .limit_i({8'h00, guard_time_i}),
        .expire_o(guard_exp)
    );

    // stops after one expiry so the fallback is taken once per silence
    period_timer life_tmr (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .run_i(guard_run && !life_done_r),
        .restart_i(guard_req),
        .limit_i(life_limit),
        .expire_o(life_exp)
    );

    period_timer hb_tmr (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .run_i(hb_run),
        .restart_i(1'b0),
        .limit_i({8'h00, hb_period_i}),
        .expire_o(hb_exp)
    );

    // fault intake: one report held until its emergency is loaded
    emcy_encoder enc (
        .fault_i(fault_i),
        .app_o(enc_app)
    );
    assign fault_ready_o = !emcy_pend_r;
    wire fault_take = ce_i && fault_valid_i && !emcy_pend_r;

    // transmit arbitration: boot, emergency, guard reply, heartbeat
    wire tx_fire = ce_i && tx_valid_r && tx_ready_i;
    wire tx_free = !tx_valid_r || tx_fire;
    wire any_pend = boot_pend_r || emcy_pend_r || guard_pend_r || hb_pend_r;
    wire tx_load = ce_i && tx_free && any_pend;
    wire sel_boot = boot_pend_r;
    wire sel_emcy = !boot_pend_r && emcy_pend_r;
    wire sel_guard = !boot_pend_r && !emcy_pend_r && guard_pend_r;
    wire sel_hb = !boot_pend_r && !emcy_pend_r && !guard_pend_r;
    wire boot_done = tx_fire && tx_boot_r;

    always_comb begin
        tx_nxt = '0;
        if (sel_boot) begin
            tx_nxt.id = emcy_id;
            tx_nxt.dlc = sup_pkg::BOOT_DLC;
        end else if (sel_emcy) begin
            tx_nxt.id = emcy_id;
            tx_nxt.dlc = sup_pkg::EMCY_DLC;
            tx_nxt.data[0] = sup_pkg::EMCY_CODE[7:0];
            tx_nxt.data[1] = sup_pkg::EMCY_CODE[15:8];
            tx_nxt.data[2] = sup_pkg::EMCY_ERR_REG;
            tx_nxt.data[7:3] = emcy_app_r;
        end else begin
            tx_nxt.id = guard_id;
            tx_nxt.dlc = sup_pkg::STATE_DLC;
            tx_nxt.data[0] = {sel_guard && toggle_r, state_r};
        end
    end

    // node state
    always_comb begin
        state_nxt = state_r;
        if (cmd_reset) begin
            state_nxt = sup_pkg::ST_INIT;
        end else if (state_r == sup_pkg::ST_INIT) begin
            if (boot_done) begin
                state_nxt = sup_pkg::ST_PREOP;
            end
        end else if (cmd_start) begin
            state_nxt = sup_pkg::ST_OPER;
        end else if (cmd_stop) begin
            state_nxt = sup_pkg::ST_STOPPED;
        end else if (cmd_preop || life_exp) begin
            state_nxt = sup_pkg::ST_PREOP;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r <= sup_pkg::ST_INIT;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tx_valid_r <= 1'b0;
            tx_boot_r <= 1'b0;
            tx_frame_r <= '0;
        end else if (tx_load) begin
            tx_valid_r <= 1'b1;
            tx_boot_r <= sel_boot;
            tx_frame_r <= tx_nxt;
        end else if (tx_fire) begin
            tx_valid_r <= 1'b0;
            tx_boot_r <= 1'b0;
        end
    end

    // pending flags: clear on load first, a same-cycle set then wins
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            boot_pend_r <= 1'b1;
            emcy_pend_r <= 1'b0;
            guard_pend_r <= 1'b0;
            hb_pend_r <= 1'b0;
            emcy_app_r <= '0;
        end else if (ce_i) begin
            if (tx_load) begin
                boot_pend_r <= boot_pend_r && !sel_boot;
                emcy_pend_r <= emcy_pend_r && !sel_emcy;
                guard_pend_r <= guard_pend_r && !sel_guard;
                hb_pend_r <= hb_pend_r && !sel_hb;
            end
            if (cmd_reset) begin
                boot_pend_r <= 1'b1;
                guard_pend_r <= 1'b0;
                hb_pend_r <= 1'b0;
            end else begin
                if (guard_req && state_r != sup_pkg::ST_INIT) begin
                    guard_pend_r <= 1'b1;
                end
                if (hb_exp) begin
                    hb_pend_r <= 1'b1;
                end
            end
            if (fault_take) begin
                emcy_pend_r <= 1'b1;
                emcy_app_r <= enc_app;
            end
        end
    end

    // guarding state
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            guard_on_r <= 1'b0;
            master_fault_r <= 1'b0;
            life_done_r <= 1'b0;
            toggle_r <= 1'b0;
        end else if (ce_i) begin
            if (cmd_reset) begin
                guard_on_r <= 1'b0;
                master_fault_r <= 1'b0;
                life_done_r <= 1'b0;
                toggle_r <= 1'b0;
            end else begin
                if (guard_req) begin
                    guard_on_r <= 1'b1;
                    master_fault_r <= 1'b0;
                    life_done_r <= 1'b0;
                end
                if (guard_exp) begin
                    master_fault_r <= 1'b1;
                end
                if (life_exp) begin
                    life_done_r <= 1'b1;
                end
                if (tx_load && sel_guard) begin
                    toggle_r <= !toggle_r;
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            node_reset_r <= 1'b0;
            comm_reset_r <= 1'b0;
        end else if (ce_i) begin
            node_reset_r <= cmd_rst_node;
            comm_reset_r <= cmd_rst_comm;
        end
    end

    assign tx_valid_o = tx_valid_r;
    assign tx_frame_o = tx_frame_r;
    assign nmt_state_o = state_r;
    assign master_fault_o = master_fault_r;
    assign guard_active_o = guard_on_r;
    assign node_reset_o = node_reset_r;
    assign comm_reset_o = comm_reset_r;

    wire tx_emcy8 = tx_valid_r && tx_frame_r.id == emcy_id && tx_frame_r.dlc == sup_pkg::EMCY_DLC;
    wire tx_state_load = tx_load && (sel_guard || sel_hb);

    a_emcy_header: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        tx_emcy8 |-> tx_frame_r.data[2:0] == {sup_pkg::EMCY_ERR_REG, sup_pkg::EMCY_CODE[15:8],
                                              sup_pkg::EMCY_CODE[7:0]})
        else $error("emergency header wrong");
    a_boot_empty: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        boot_done |-> tx_frame_r.dlc == sup_pkg::BOOT_DLC && tx_frame_r.id == emcy_id)
        else $error("boot emergency not empty");
    a_init_preop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        boot_done && state_r == sup_pkg::ST_INIT && !cmd_reset |=> state_r == sup_pkg::ST_PREOP)
        else $error("no preop after boot");
    a_nmt_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        cmd_start && state_r != sup_pkg::ST_INIT |=> state_r == sup_pkg::ST_OPER)
        else $error("start command ignored");
    a_nmt_foreign: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && nmt_frame && !nmt_mine && !boot_done && !life_exp |=> $stable(state_r))
        else $error("acted on foreign node");
    a_guard_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !guard_on_r |-> !master_fault_r && !life_exp)
        else $error("guard fault before first request");
    a_life_fall: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        life_exp && state_r == sup_pkg::ST_OPER && !nmt_hit |=> state_r == sup_pkg::ST_PREOP)
        else $error("no fallback on lifetime");
    a_guard_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !guard_en |-> !guard_exp && !life_exp)
        else $error("expiry while disabled");
    a_hb_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hb_period_i == 16'h0000 |-> !hb_exp)
        else $error("heartbeat while period zero");
    a_state_id: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        tx_state_load |=> tx_frame_r.id == $past(guard_id) && tx_frame_r.dlc == sup_pkg::STATE_DLC
        && tx_frame_r.data[0][6:0] == $past(state_r))
        else $error("state frame wrong");
    a_toggle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        tx_load && sel_guard && !cmd_reset |=> toggle_r != $past(toggle_r))
        else $error("guard toggle stuck");
    a_nmt_len: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rx_valid_i && rx_frame_i.id == sup_pkg::NMT_ID && rx_frame_i.dlc != sup_pkg::NMT_DLC
        && !boot_done && !life_exp |=> $stable(state_r))
        else $error("bad length command taken");

    c_boot: cover property (@(posedge clock_i) disable iff (!rst_n_i) boot_done);
    c_start: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        cmd_start ##1 state_r == sup_pkg::ST_OPER);
    c_guard: cover property (@(posedge clock_i) disable iff (!rst_n_i) tx_load && sel_guard);
    c_emcy: cover property (@(posedge clock_i) disable iff (!rst_n_i) tx_emcy8 && tx_fire);
    c_life: cover property (@(posedge clock_i) disable iff (!rst_n_i) life_exp);
endmodule

// ---- testbench/can_master_model.sv ----
// far-end bus master: takes transmitted frames and sends frames to the node
// assumes the node's valid/ready transmit side and one-cycle receive strobe
`timescale 1ns/100ps
module can_master_model (
    // clock and pacing
    input wire logic clock_i,
    input wire logic slow_i,
    // node transmit side
    input wire logic tx_valid_i,
    input wire sup_pkg::can_frame_t tx_frame_i,
    output logic tx_ready_o,
    // node receive side
    output logic rx_valid_o,
    output sup_pkg::can_frame_t rx_frame_o
);
    int got = 0;
    sup_pkg::can_frame_t last;
    logic [1:0] pace = 2'h0;
    initial begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_frame_o = '0;
    end
    // slow mode takes at most one frame in four cycles
    always @(negedge clock_i) begin
        pace <= pace + 2'h1;
        tx_ready_o <= !slow_i || (pace == 2'h3);
    end
    always @(posedge clock_i) begin
        if (tx_valid_i && tx_ready_o) begin
            last <= tx_frame_i;
            got <= got + 1;
        end
    end
    // idle bus shows the inverse so a stale frame never looks valid
    task automatic send(input sup_pkg::can_frame_t f);
        @(negedge clock_i);
        rx_valid_o = 1'b1;
        rx_frame_o = f;
        @(negedge clock_i);
        rx_valid_o = 1'b0;
        rx_frame_o = ~f;
    endtask
endmodule

// ---- testbench/canopen_node_supervision_bench.sv ----
// self-checking bench for the node supervision block
// assumes the master model beside it and a ten-cycle millisecond tick
`timescale 1ns/100ps
module canopen_node_supervision_bench;
    localparam logic [6:0] NODE = 7'h05;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic slow = 1'b0;
    logic fault_valid = 1'b0;
    logic [7:0] life = 8'h00;
    logic [15:0] hb = 16'h0000;
    sup_pkg::fault_t fault = '0;
    logic tx_valid, tx_ready, rx_valid, fault_ready, m_fault, g_act, n_rst, c_rst;
    sup_pkg::can_frame_t tx_frame, rx_frame;
    sup_pkg::nmt_state_t state;
    int num_errors = 0;
    int tests_run = 0;
    int n = 0;
    always #5 clock_i = ~clock_i;
    canopen_node_supervision #(.TICK_CYCLES_P(10)) canopen_node_supervision_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .node_id_i(NODE),
        .guard_time_i(16'h0003), .life_factor_i(life), .hb_period_i(hb),
        .rx_valid_i(rx_valid), .rx_frame_i(rx_frame), .tx_valid_o(tx_valid),
        .tx_frame_o(tx_frame), .tx_ready_i(tx_ready), .fault_valid_i(fault_valid),
        .fault_i(fault), .fault_ready_o(fault_ready), .nmt_state_o(state),
        .master_fault_o(m_fault), .guard_active_o(g_act), .node_reset_o(n_rst),
        .comm_reset_o(c_rst));
    can_master_model can_master_model_i (.clock_i(clock_i), .slow_i(slow),
        .tx_valid_i(tx_valid), .tx_frame_i(tx_frame), .tx_ready_o(tx_ready),
        .rx_valid_o(rx_valid), .rx_frame_o(rx_frame));
    function automatic sup_pkg::can_frame_t fr(logic [10:0] id, logic rtr, logic [3:0] dlc,
            logic [63:0] d);
        fr = {id, rtr, dlc, d};
    endfunction
    task automatic chk_val(input logic [7:0] g, input logic [7:0] e, input string s);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, s, g, e);
        end
    endtask
    // header-only compare where the data bytes are not defined
    task automatic chk_frame(input sup_pkg::can_frame_t e, input logic all);
        sup_pkg::can_frame_t g;
        g = can_master_model_i.last;
        tests_run++;
        if (g[79:64] !== e[79:64] || (all && g !== e)) begin
            num_errors++;
            $display("CHECK FAILED at %0t: frame %h want %h", $time, g, e);
        end
    endtask
    task automatic wait_frame();
        for (int i = 0; i < 300 && can_master_model_i.got == n; i++) @(negedge clock_i);
        chk_val(8'(can_master_model_i.got - n), 8'h01, "frame count");
        n = can_master_model_i.got;
    endtask
    task automatic nmt_case(input logic [7:0] cmd, input logic [7:0] node,
            input logic [3:0] dlc, input logic [7:0] st);
        can_master_model_i.send(fr(11'h000, 1'b0, dlc, {48'h0, node, cmd}));
        chk_val({1'b0, state}, st, "state");
    endtask
    task automatic fault_case(input sup_pkg::fault_t f, input logic [39:0] app);
        logic [39:0] r;
        r = {<<8{app}};
        fault = f;
        fault_valid = 1'b1;
        for (int i = 0; i < 200 && fault_ready !== 1'b1; i++) @(negedge clock_i);
        @(negedge clock_i);
        fault_valid = 1'b0;
        chk_val({7'h0, fault_ready}, 8'h00, "fault busy");
        wait_frame();
        chk_frame(fr(11'h080 + NODE, 1'b0, 4'h8, {r, 24'h811000}), 1'b1);
    endtask
    task automatic t_main();
        logic [7:0] t0;
        wait_frame();
        chk_frame(fr(11'h080 + NODE, 1'b0, 4'h0, 64'h0), 1'b0);
        @(negedge clock_i);
        chk_val({1'b0, state}, 8'h7F, "boot state");
        nmt_case(8'h01, {1'b0, NODE}, 4'h2, 8'h05);
        nmt_case(8'h02, 8'h00, 4'h2, 8'h04);
        nmt_case(8'h01, 8'h06, 4'h2, 8'h04);
        nmt_case(8'h01, {1'b0, NODE}, 4'h3, 8'h04);
        nmt_case(8'h80, {1'b0, NODE}, 4'h2, 8'h7F);
        nmt_case(8'h01, 8'h00, 4'h2, 8'h05);
        $display("test nmt done");
        slow = 1'b1;
        fault_case({4'h0, 3'h0, 8'h07, 32'hFFFFFFFF}, 40'h0100000000);
        fault_case({4'h1, 3'h0, 8'h03, 32'hFFFF0209}, 40'h0203090200);
        fault_case({4'h2, 3'h0, 8'h07, 32'hFFFFFFFF}, 40'h0300000000);
        fault_case({4'h3, 3'h0, 8'h07, 32'hFFFFFFFF}, 40'h1000000000);
        fault_case({4'h4, 3'h0, 8'h07, 32'hFFFFFFFF}, 40'h1100000000);
        fault_case({4'h5, 3'h0, 8'h02, 32'hFFFF0401}, 40'h2002010400);
        fault_case({4'h5, 3'h7, 8'h02, 32'hFFFF0401}, 40'h2702010400);
        fault_case({4'h6, 3'h3, 8'h04, 32'hFFFF0C05}, 40'h3304050C00);
        fault_case({4'h7, 3'h0, 8'h05, 32'h44332211}, 40'h4511223344);
        fault_case({4'h8, 3'h0, 8'h06, 32'h44332211}, 40'h8611223344);
        fault_case({4'h9, 3'h0, 8'h01, 32'hFF011064}, 40'hAA64100100);
        slow = 1'b0;
        $display("test emergency done");
        hb = 16'h0002;
        wait_frame();
        chk_frame(fr(11'h700 + NODE, 1'b0, 4'h1, 64'h0), 1'b0);
        chk_val(can_master_model_i.last.data[0], 8'h05, "beat");
        hb = 16'h0000;
        repeat (5) @(negedge clock_i);
        n = can_master_model_i.got;
        repeat (100) @(negedge clock_i);
        chk_val(8'(can_master_model_i.got - n), 8'h00, "beat off");
        $display("test heartbeat done");
        chk_val({7'h0, g_act}, 8'h00, "idle guard");
        can_master_model_i.send(fr(11'h700 + NODE, 1'b1, 4'h0, 64'h0));
        wait_frame();
        chk_frame(fr(11'h700 + NODE, 1'b0, 4'h1, 64'h0), 1'b0);
        t0 = can_master_model_i.last.data[0];
        chk_val({1'b0, t0[6:0]}, 8'h05, "reply");
        chk_val({7'h0, g_act}, 8'h01, "guarding");
        repeat (100) @(negedge clock_i);
        chk_val({1'b0, state}, 8'h05, "no expiry");
        life = 8'h02;
        can_master_model_i.send(fr(11'h700 + NODE, 1'b1, 4'h0, 64'h0));
        wait_frame();
        chk_val(can_master_model_i.last.data[0], t0 ^ 8'h80, "toggle");
        repeat (45) @(negedge clock_i);
        chk_val({6'h0, m_fault, state == sup_pkg::ST_OPER}, 8'h03, "miss");
        repeat (40) @(negedge clock_i);
        chk_val({1'b0, state}, 8'h7F, "lifetime");
        $display("test guarding done");
    endtask
    task automatic t_reset();
        int p;
        for (int c = 0; c < 2; c++) begin
            p = 0;
            can_master_model_i.send(fr(11'h000, 1'b0, 4'h2, {48'h0, 1'b0, NODE, 8'h81 + 8'(c)}));
            // the pulse already stands at the negedge on which send returns
            repeat (4) begin
                p += c ? c_rst : n_rst;
                @(negedge clock_i);
            end
            chk_val(8'(p), 8'h01, "reset pulse");
            wait_frame();
            chk_frame(fr(11'h080 + NODE, 1'b0, 4'h0, 64'h0), 1'b0);
            @(negedge clock_i);
            chk_val({6'h0, g_act, state == sup_pkg::ST_PREOP}, 8'h01, "reboot");
        end
        $display("test reset done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        t_main();
        t_reset();
        final_report();
    end
    // whole run is near 400 cycles
    initial begin
        #100us;
        num_errors++;
        final_report();
    end
endmodule
